// ==== src/pllsr_map.svh ====
// Register indices, field positions and reset values of the loop status bank.
`ifndef PLLSR_MAP_SVH
`define PLLSR_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PLLSR_IDX_UPDATE 12'h005
`define PLLSR_IDX_LOCK 12'hd20
`define PLLSR_IDX_STATE 12'hd21
`define PLLSR_IDX_LIMIT 12'hd22
`define PLLSR_IDX_TUNE0 12'hd23
`define PLLSR_IDX_TUNE1 12'hd24
`define PLLSR_IDX_TUNE2 12'hd25
`define PLLSR_IDX_TUNE3 12'hd26
`define PLLSR_IDX_PBKT_LO 12'hd27
`define PLLSR_IDX_PBKT_HI 12'hd28
`define PLLSR_IDX_FBKT_LO 12'hd29
`define PLLSR_IDX_FBKT_HI 12'hd2a

// ****************************************************************
// Update strobe value
// ****************************************************************
`define PLLSR_UPDATE_CMD 8'h01

// ****************************************************************
// Field positions
// ****************************************************************
`define PLLSR_LK_CAL 4
`define PLLSR_LK_APLL 3
`define PLLSR_LK_FREQ 2
`define PLLSR_LK_PHASE 1
`define PLLSR_LK_ALL 0
`define PLLSR_ST_REF_HI 4
`define PLLSR_ST_REF_LO 3
`define PLLSR_ST_SWITCH 2
`define PLLSR_ST_HOLD 1
`define PLLSR_ST_FREE 0
`define PLLSR_LM_SLEW 2
`define PLLSR_LM_CLAMP 1
`define PLLSR_LM_HIST 0

// ****************************************************************
// Reset values
// ****************************************************************
`define PLLSR_RST_BYTE 8'h00
`define PLLSR_RST_WORD 32'h0000_0000

`endif

// ==== src/pllsr_pkg.sv ====
// Types shared by the loop status bank: bus request and status carriers.
package pllsr_pkg;

    // ****************************************************************
    // Classic Wishbone request from the master
    // ****************************************************************
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [13:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pllsr_wb_req_s;

    // ****************************************************************
    // Live status presented by the loops
    // ****************************************************************
    typedef struct packed {
        logic sysclk_lock;
        logic cal_busy;
        logic apll_lock;
        logic dpll_freq_lock;
        logic dpll_phase_lock;
        logic [1:0] active_ref;
        logic switching;
        logic holdover;
        logic free_run;
        logic slew_limited;
        logic freq_clamped;
        logic history_avail;
        logic [29:0] tuning_avg;
        logic [29:0] tuning_live;
        logic [11:0] phase_bucket;
        logic [11:0] freq_bucket;
    } pllsr_live_s;

    // ****************************************************************
    // Snapshot held for software
    // ****************************************************************
    typedef struct packed {
        logic all_lock;
        logic cal_busy;
        logic apll_lock;
        logic dpll_freq_lock;
        logic dpll_phase_lock;
        logic [1:0] active_ref;
        logic switching;
        logic holdover;
        logic free_run;
        logic slew_limited;
        logic freq_clamped;
        logic history_avail;
        logic [29:0] tuning;
        logic [11:0] phase_bucket;
        logic [11:0] freq_bucket;
    } pllsr_snap_s;

endpackage : pllsr_pkg

// ==== src/pllsr_status_bank.sv ====
// Snapshot status bank of the first loop channel behind a Wishbone slave.
//
// Implementation choice: the Wishbone interface to the registers.
`include "pllsr_map.svh"

module pllsr_status_bank
    import pllsr_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave.
    input wire pllsr_wb_req_s wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Loop status.
    input wire pllsr_live_s live_i,
    input wire logic hist_timer_min_i
);

    // ****************************************************************
    // Byte assembly
    // ****************************************************************

    // Builds the byte shown at one register index from the snapshot.
    function automatic logic [7:0] reg_byte(
        input logic [11:0] idx,
        input pllsr_snap_s s
    );
        logic [7:0] b;
        b = `PLLSR_RST_BYTE;
        unique case (idx)
            `PLLSR_IDX_LOCK: begin
                b[`PLLSR_LK_CAL] = s.cal_busy;
                b[`PLLSR_LK_APLL] = s.apll_lock;
                b[`PLLSR_LK_FREQ] = s.dpll_freq_lock;
                b[`PLLSR_LK_PHASE] = s.dpll_phase_lock;
                b[`PLLSR_LK_ALL] = s.all_lock;
            end
            `PLLSR_IDX_STATE: begin
                b[`PLLSR_ST_REF_HI:`PLLSR_ST_REF_LO] = s.active_ref;
                b[`PLLSR_ST_SWITCH] = s.switching;
                b[`PLLSR_ST_HOLD] = s.holdover;
                b[`PLLSR_ST_FREE] = s.free_run;
            end
            `PLLSR_IDX_LIMIT: begin
                b[`PLLSR_LM_SLEW] = s.slew_limited;
                b[`PLLSR_LM_CLAMP] = s.freq_clamped;
                b[`PLLSR_LM_HIST] = s.history_avail;
            end
            // Tuning word, least significant byte first.
            `PLLSR_IDX_TUNE0: b = s.tuning[7:0];
            `PLLSR_IDX_TUNE1: b = s.tuning[15:8];
            `PLLSR_IDX_TUNE2: b = s.tuning[23:16];
            `PLLSR_IDX_TUNE3: b[5:0] = s.tuning[29:24];
            // Bucket levels, upper nibbles stay zero.
            `PLLSR_IDX_PBKT_LO: b = s.phase_bucket[7:0];
            `PLLSR_IDX_PBKT_HI: b[3:0] = s.phase_bucket[11:8];
            `PLLSR_IDX_FBKT_LO: b = s.freq_bucket[7:0];
            `PLLSR_IDX_FBKT_HI: b[3:0] = s.freq_bucket[11:8];
            default: b = `PLLSR_RST_BYTE;
        endcase
        return b;
    endfunction : reg_byte

    // Captures one consistent sample of the live fields, keeping only one of the two tuning words.
    function automatic pllsr_snap_s take_snap(
        input pllsr_live_s l,
        input logic timer_min
    );
        pllsr_snap_s s;
        s.all_lock = l.sysclk_lock & l.apll_lock & l.dpll_phase_lock;
        s.cal_busy = l.cal_busy;
        s.apll_lock = l.apll_lock;
        s.dpll_freq_lock = l.dpll_freq_lock;
        s.dpll_phase_lock = l.dpll_phase_lock;
        s.active_ref = l.active_ref;
        s.switching = l.switching;
        s.holdover = l.holdover;
        s.free_run = l.free_run;
        s.slew_limited = l.slew_limited;
        s.freq_clamped = l.freq_clamped;
        s.history_avail = l.history_avail;
        // A minimal history timer makes the average meaningless.
        s.tuning = timer_min ? l.tuning_live : l.tuning_avg;
        s.phase_bucket = l.phase_bucket;
        s.freq_bucket = l.freq_bucket;
        return s;
    endfunction : take_snap

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic [11:0] req_idx;
    logic req_new;
    logic upd_fire;
    pllsr_snap_s snap_reg;
    pllsr_snap_s snap_next;

    // The request index drops the two byte-lane bits.
    assign req_idx = wb_req_i.adr[13:2];

    // A request is served once; ack drops in the following cycle.
    assign req_new = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;

    // Update command: write of 0x01 on lane 0 of the update index.
    assign upd_fire = req_new & wb_req_i.we & wb_req_i.sel[0]
        & (req_idx == `PLLSR_IDX_UPDATE)
        & (wb_req_i.dat[7:0] == `PLLSR_UPDATE_CMD);

    // ****************************************************************
    // Bus answer
    // ****************************************************************

    // Next ack and read data; unmapped reads return zero.
    always_comb begin
        ack_next = req_new;
        dat_next = dat_reg;
        if (req_new && !wb_req_i.we) begin
            dat_next = {24'h00_0000, reg_byte(req_idx, snap_reg)};
        end
    end

    // Registers the answer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= `PLLSR_RST_WORD;
        end else if (ce_i) begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ****************************************************************
    // Snapshot
    // ****************************************************************

    // Only the update command loads the bank; other writes are dropped.
    always_comb begin
        snap_next = snap_reg;
        if (upd_fire) begin
            snap_next = take_snap(live_i, hist_timer_min_i);
        end
    end

    // Registers the snapshot.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            snap_reg <= '0;
        end else if (ce_i) begin
            snap_reg <= snap_next;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    logic rd_ack;

    // A read answer is on the bus while the read request is held.
    assign rd_ack = ack_reg & ~wb_req_i.we;

    chk_bank_read_only: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !upd_fire |=> snap_reg == $past(snap_reg)
    ) else $error("Status bank changed without an update.");

    chk_update_capture: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd_fire && ce_i |=> snap_reg.cal_busy == $past(live_i.cal_busy)
            && snap_reg.active_ref == $past(live_i.active_ref)
    ) else $error("Update did not capture live status.");

    chk_cal_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_LOCK
            |-> wb_dat_o[4] == snap_reg.cal_busy
    ) else $error("Calibration bit wrong.");

    chk_apll_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_LOCK
            |-> wb_dat_o[3] == snap_reg.apll_lock
    ) else $error("Analog lock bit wrong.");

    chk_freq_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_LOCK
            |-> wb_dat_o[2] == snap_reg.dpll_freq_lock
    ) else $error("Frequency lock bit wrong.");

    chk_phase_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_LOCK
            |-> wb_dat_o[1] == snap_reg.dpll_phase_lock
    ) else $error("Phase lock bit wrong.");

    chk_all_locked: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd_fire && ce_i |=> snap_reg.all_lock == ($past(live_i.sysclk_lock)
            && $past(live_i.apll_lock) && $past(live_i.dpll_phase_lock))
    ) else $error("All-locked flag wrong.");

    chk_ref_field: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_STATE
            |-> wb_dat_o[4:3] == snap_reg.active_ref
    ) else $error("Active reference field wrong.");

    chk_switch_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_STATE
            |-> wb_dat_o[2] == snap_reg.switching
    ) else $error("Switching bit wrong.");

    chk_holdover_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_STATE
            |-> wb_dat_o[1] == snap_reg.holdover
    ) else $error("Holdover bit wrong.");

    chk_free_run_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_STATE
            |-> wb_dat_o[0] == snap_reg.free_run
    ) else $error("Free run bit wrong.");

    chk_slew_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_LIMIT
            |-> wb_dat_o[2] == snap_reg.slew_limited
    ) else $error("Slew limit bit wrong.");

    chk_clamp_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_LIMIT
            |-> wb_dat_o[1] == snap_reg.freq_clamped
    ) else $error("Clamp bit wrong.");

    chk_history_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_LIMIT
            |-> wb_dat_o[0] == snap_reg.history_avail
    ) else $error("History bit wrong.");

    chk_tuning_top: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_TUNE3
            |-> wb_dat_o[7:0] == {2'b00, snap_reg.tuning[29:24]}
    ) else $error("Tuning word top byte wrong.");

    chk_tuning_select: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd_fire && ce_i |=> snap_reg.tuning == ($past(hist_timer_min_i)
            ? $past(live_i.tuning_live) : $past(live_i.tuning_avg))
    ) else $error("Tuning word source wrong.");

    chk_phase_bucket: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_PBKT_HI
            |-> wb_dat_o[7:0] == {4'h0, snap_reg.phase_bucket[11:8]}
    ) else $error("Phase bucket high byte wrong.");

    chk_freq_bucket: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_FBKT_LO
            |-> wb_dat_o[7:0] == snap_reg.freq_bucket[7:0]
    ) else $error("Frequency bucket low byte wrong.");

    chk_reserved_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx >= `PLLSR_IDX_LOCK && req_idx <= `PLLSR_IDX_LIMIT
            |-> wb_dat_o[31:5] == 27'h0 && (req_idx == `PLLSR_IDX_STATE
            || req_idx == `PLLSR_IDX_LOCK || wb_dat_o[4:3] == 2'b00)
    ) else $error("Reserved bits not zero.");

    chk_joint_capture: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd_fire && ce_i
            |=> snap_reg.phase_bucket == $past(live_i.phase_bucket)
            && snap_reg.freq_bucket == $past(live_i.freq_bucket)
    ) else $error("Bucket levels not captured together.");

    chk_ack_single: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_reg && ce_i |=> !ack_reg
    ) else $error("Ack held for more than one cycle.");

    chk_tuning_byte0: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_TUNE0
            |-> wb_dat_o[7:0] == snap_reg.tuning[7:0]
    ) else $error("Tuning word low byte wrong.");

    chk_tuning_byte1: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_TUNE1
            |-> wb_dat_o[7:0] == snap_reg.tuning[15:8]
    ) else $error("Tuning word second byte wrong.");

    chk_tuning_byte2: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_TUNE2
            |-> wb_dat_o[7:0] == snap_reg.tuning[23:16]
    ) else $error("Tuning word third byte wrong.");

    chk_phase_bucket_low: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_PBKT_LO
            |-> wb_dat_o[7:0] == snap_reg.phase_bucket[7:0]
    ) else $error("Phase bucket low byte wrong.");

    chk_freq_bucket_high: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && req_idx == `PLLSR_IDX_FBKT_HI
            |-> wb_dat_o[7:0] == {4'h0, snap_reg.freq_bucket[11:8]}
    ) else $error("Frequency bucket high byte wrong.");

    chk_flags_capture: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd_fire && ce_i |=> snap_reg.switching == $past(live_i.switching)
            && snap_reg.holdover == $past(live_i.holdover)
            && snap_reg.free_run == $past(live_i.free_run)
    ) else $error("Loop state flags not captured together.");

    // Unmapped indices and the update register read as zero.
    chk_unmapped_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ack && (req_idx < `PLLSR_IDX_LOCK || req_idx > `PLLSR_IDX_FBKT_HI)
            |-> wb_dat_o == 32'h0000_0000
    ) else $error("Unmapped read not zero.");

    chk_ack_after_take: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req_new && ce_i |=> ack_reg
    ) else $error("Taken request not acknowledged.");

    chk_read_data_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(req_new && !wb_req_i.we && ce_i) |=> $stable(wb_dat_o)
    ) else $error("Read data changed without a read.");

    chk_ce_freeze: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(snap_reg) && $stable(ack_reg) && $stable(dat_reg)
    ) else $error("State changed while the clock enable was low.");

endmodule : pllsr_status_bank

// ==== dv/tb_pllsr_status_bank.sv ====
// Self-checking testbench of the loop status bank with a snapshot model.
`include "pllsr_map.svh"

module tb_pllsr_status_bank
    import pllsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and model state
    // ****************************************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    pllsr_wb_req_s wb_req = '0;
    logic [31:0] wb_dat;
    logic wb_ack;
    pllsr_live_s live = '0;
    logic timer_min = 1'b0;
    logic [3:0] sel_use = 4'h1;
    logic [7:0] exp_q [11];
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    // Clock at 200 MHz.
    always #2.5 clk_i = ~clk_i;

    // Device under test.
    pllsr_status_bank DUT (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wb_req_i(wb_req),
        .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack),
        .live_i(live),
        .hist_timer_min_i(timer_min)
    );

    // ****************************************************************
    // Reporting
    // ****************************************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    // Compares one read value with the model.
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            err_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, want);
        end
    endtask : cmp

    // Cuts a hang short; the tests need well under this many cycles.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end

    // ****************************************************************
    // Bus master and model
    // ****************************************************************
    // One classic cycle; entered just after a rising edge, leaves one idle cycle.
    task automatic wb_cycle(input logic we, input logic [11:0] idx, input logic [7:0] d,
                            output logic [31:0] q);
        wb_req.cyc <= 1'b1;
        wb_req.stb <= 1'b1;
        wb_req.we <= we;
        wb_req.adr <= {idx, 2'b00};
        wb_req.sel <= sel_use;
        wb_req.dat <= {24'h00_0000, d};
        // Waits for the answer; only the bench timeout ends a hang.
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        q = wb_dat;
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
        wb_req.we <= 1'b0;
        @(posedge clk_i);
    endtask : wb_cycle

    // Model of the capture at an update write.
    task automatic capture(input pllsr_live_s l, input logic tmin);
        logic [29:0] tw;
        tw = tmin ? l.tuning_live : l.tuning_avg;
        exp_q[0] = {3'b000, l.cal_busy, l.apll_lock, l.dpll_freq_lock, l.dpll_phase_lock,
                    l.sysclk_lock & l.apll_lock & l.dpll_phase_lock};
        exp_q[1] = {3'b000, l.active_ref, l.switching, l.holdover, l.free_run};
        exp_q[2] = {5'b00000, l.slew_limited, l.freq_clamped, l.history_avail};
        exp_q[3] = tw[7:0];
        exp_q[4] = tw[15:8];
        exp_q[5] = tw[23:16];
        exp_q[6] = {2'b00, tw[29:24]};
        exp_q[7] = l.phase_bucket[7:0];
        exp_q[8] = {4'h0, l.phase_bucket[11:8]};
        exp_q[9] = l.freq_bucket[7:0];
        exp_q[10] = {4'h0, l.freq_bucket[11:8]};
    endtask : capture

    // Reads all eleven status bytes and compares each with the model.
    task automatic check_bank();
        logic [31:0] q;
        for (int k = 0; k < 11; k++) begin
            wb_cycle(1'b0, `PLLSR_IDX_LOCK + 12'(k), 8'h00, q);
            cmp(q, {24'h00_0000, exp_q[k]});
        end
    endtask : check_bank

    // Returns a random live status word.
    function automatic pllsr_live_s rand_live();
        logic [127:0] r;
        r = {$urandom(), $urandom(), $urandom(), $urandom()};
        return r[$bits(pllsr_live_s)-1:0];
    endfunction : rand_live

    // Applies reset for four cycles and clears the model.
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        capture('0, 1'b0);
        @(posedge clk_i);
    endtask : do_reset

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] q;
        pllsr_live_s lv;
        void'($urandom(53547));
        do_reset();
        // Bank reads zero after reset; update and unmapped places read zero.
        check_bank();
        wb_cycle(1'b0, `PLLSR_IDX_UPDATE, 8'h00, q);
        cmp(q, 32'h0000_0000);
        wb_cycle(1'b0, 12'hd2b, 8'h00, q);
        cmp(q, 32'h0000_0000);
        // Random captures covering every reference code, both timer modes, full lock.
        for (int i = 0; i < 16; i++) begin
            lv = rand_live();
            lv.active_ref = i[1:0];
            if (i >= 8) begin
                lv.sysclk_lock = 1'b1;
                lv.apll_lock = 1'b1;
                lv.dpll_phase_lock = 1'b1;
            end
            live <= lv;
            timer_min <= i[2];
            @(posedge clk_i);
            wb_cycle(1'b1, `PLLSR_IDX_UPDATE, `PLLSR_UPDATE_CMD, q);
            capture(lv, i[2]);
            live <= rand_live();
            timer_min <= ~i[2];
            check_bank();
        end
        // Writes to status bytes and a wrong update value change nothing.
        for (int k = 0; k < 11; k++) begin
            wb_cycle(1'b1, `PLLSR_IDX_LOCK + 12'(k), 8'(~$urandom()), q);
        end
        wb_cycle(1'b1, `PLLSR_IDX_UPDATE, 8'h02, q);
        check_bank();
        // An update command on the wrong byte lane is ignored as well.
        sel_use = 4'h2;
        wb_cycle(1'b1, `PLLSR_IDX_UPDATE, `PLLSR_UPDATE_CMD, q);
        sel_use = 4'h1;
        check_bank();
        // Clock enable low stalls a read without changing its result.
        ce_i <= 1'b0;
        fork
            wb_cycle(1'b0, `PLLSR_IDX_STATE, 8'h00, q);
            begin
                repeat (4) @(posedge clk_i);
                ce_i <= 1'b1;
            end
        join
        cmp(q, {24'h00_0000, exp_q[1]});
        // A second reset clears the snapshot.
        do_reset();
        check_bank();
        summarize();
    end

endmodule : tb_pllsr_status_bank
